// [rcd_clock_partner.sv]
`timescale 1ns/100ps
module rcd_clock_partner(
  input wire logic osc_on_i, // oscillator powered
  input wire logic sleep_i, // device asleep
  input wire logic pin_i, // reference output
  input wire logic clr_i, // clear edge count
  output logic posc_o, // primary oscillator
  output logic sys_o, // system clock
  output int rises_o // pin rising edges
);
  logic pr = 1'b0;
  logic sr = 1'b0;
  initial #7 forever #200 pr = ~pr;
  initial #13 forever #400 sr = ~sr;
  // Stopped clocks sit low, never frozen high
  assign posc_o = pr & osc_on_i;
  assign sys_o = sr & ~sleep_i;
  always @(posedge pin_i or posedge clr_i)
    if (clr_i)
      rises_o <= 0;
    else
      rises_o <= rises_o + 1;
endmodule

// [rcd_defines.svh]
`ifndef RCD_DEFINES_SVH
`define RCD_DEFINES_SVH

// Word offsets on the register bus (byte addresses)
`define RCD_ADR_CTRL 8'h00
`define RCD_ADR_OSC 8'h04
`define RCD_ADR_STAT 8'h08

// Control register field positions
`define RCD_BIT_EN 15
`define RCD_BIT_SLP 13
`define RCD_BIT_SRC 12
`define RCD_DIV_HI 11
`define RCD_DIV_LO 8

// Reset values
`define RCD_CTRL_RST 16'h0000
`define RCD_OSC_RST 1'b0

// Largest divisor code, divide by 32,768
`define RCD_DIV_MAX 4'hf

`endif

// [rcd_pkg.sv]
package rcd_pkg;

  typedef struct packed {
    logic enable;
    logic run_in_sleep;
    logic source_select;
    logic [3:0] divisor_select;
  } rcd_ctrl_t;

  typedef struct packed {
    logic running;
    logic osc_powered;
    logic out_level;
  } rcd_stat_t;

  typedef enum logic [1:0] {
    RCD_IDLE = 2'b00,
    RCD_RUN = 2'b01
  } rcd_state_t;

endpackage

// [rcd_ref_clock.sv]
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "rcd_defines.svh"
// Summary of operation
// - With the output enable bit set the divided clock drives the pin.
// - With source select set the primary oscillator is the base clock.
// - With source select clear the system clock is the base clock.
// - The run-in-sleep bit decides whether the output runs during Sleep.
// - In Sleep the output runs only with run-in-sleep and source both set.
// - Sleep powers the oscillator down unless primary mode or keep-alive.
// - The divisor field divides the base clock by two to that power.
// - The output works in every oscillator configuration while awake; in Sleep it also needs the oscillator powered.
// - Bit 14 and the low byte ignore writes and read as zero.
module rcd_ref_clock
  import rcd_pkg::*;
(
  input wire logic clk_i, // 20 MHz peripheral clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic wb_we_i, // Write enable
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  output logic wb_ack_o, // Acknowledge
  input wire logic primary_osc_i, // Primary oscillator clock
  input wire logic system_clock_i, // Current system clock
  input wire logic sleep_i, // Device in Sleep
  input wire logic primary_mode_i, // Device clock in a primary mode
  output logic primary_osc_enable_o, // Primary oscillator powered
  output logic ref_clock_pin_o // Reference clock output
);

  rcd_ctrl_t ctrl, next_ctrl;
  logic keep_alive, next_keep_alive;
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;

  // Three-stage samplers for the foreign base clocks
  logic [2:0] posc_sync, sys_sync;
  logic posc_flt, next_posc_flt, sys_flt, next_sys_flt;

  rcd_state_t state, next_state;
  logic act_src, next_act_src;
  logic [3:0] act_div, next_act_div;
  logic [14:0] cnt, next_cnt;
  logic out, next_out;

  logic req, base_lvl, base_rise, osc_on, run_ok;
  logic [14:0] half;
  rcd_stat_t stat;

  assign req = wb_cyc_i & wb_stb_i;

  // Sleep power-down
  // oscillator shut off
  assign osc_on = ~sleep_i | primary_mode_i | keep_alive;

  assign run_ok = ctrl.enable &
    (~sleep_i | (ctrl.run_in_sleep & ctrl.source_select & osc_on));

  // A change counts only once stages two and three agree
  assign next_posc_flt = (posc_sync[1] == posc_sync[2]) ? posc_sync[2]
                                                        : posc_flt;
  assign next_sys_flt = (sys_sync[1] == sys_sync[2]) ? sys_sync[2]
                                                     : sys_flt;

  assign base_lvl = act_src ? posc_flt : sys_flt;
  assign base_rise = act_src ? (next_posc_flt & ~posc_flt)
                             : (next_sys_flt & ~sys_flt);

  // Half period in base edges, 2^(div-1)
  assign half = (act_div == 4'h0) ? 15'h0001
              : (15'h0001 << (act_div - 4'h1));

  assign stat = '{running: (state == RCD_RUN), osc_powered: osc_on,
                  out_level: out};

  always_comb
  begin
    next_ctrl = ctrl;
    next_keep_alive = keep_alive;
    next_ack = req & ~ack;
    next_rdata = 32'h0000_0000;
    if (req & ~ack)
    begin
      case (wb_adr_i)
        `RCD_ADR_CTRL:
        begin
          if (wb_we_i & wb_sel_i[1])
          begin
            next_ctrl.enable = wb_dat_i[`RCD_BIT_EN];
            next_ctrl.run_in_sleep = wb_dat_i[`RCD_BIT_SLP];
            next_ctrl.source_select = wb_dat_i[`RCD_BIT_SRC];
            next_ctrl.divisor_select = wb_dat_i[`RCD_DIV_HI:`RCD_DIV_LO];
          end
          next_rdata[`RCD_BIT_EN] = ctrl.enable;
          next_rdata[`RCD_BIT_SLP] = ctrl.run_in_sleep;
          next_rdata[`RCD_BIT_SRC] = ctrl.source_select;
          next_rdata[`RCD_DIV_HI:`RCD_DIV_LO] = ctrl.divisor_select;
        end
        `RCD_ADR_OSC:
        begin
          if (wb_we_i & wb_sel_i[0])
            next_keep_alive = wb_dat_i[0];
          next_rdata[0] = keep_alive;
        end
        `RCD_ADR_STAT:
          next_rdata[2:0] = stat;
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= rcd_ctrl_t'(7'(`RCD_CTRL_RST));
      keep_alive <= `RCD_OSC_RST;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      ctrl <= next_ctrl;
      keep_alive <= next_keep_alive;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

  // Divider; settings are adopted only while the pin is low
  // in Sleep it runs only while the oscillator is powered (osc_on)
  always_comb
  begin
    next_state = state;
    next_act_src = act_src;
    next_act_div = act_div;
    next_cnt = cnt;
    next_out = out;
    case (state)
      RCD_IDLE:
      begin
        next_out = 1'b0;
        next_cnt = 15'h0000;
        next_act_src = ctrl.source_select;
        next_act_div = ctrl.divisor_select;
        if (run_ok)
          next_state = RCD_RUN;
      end
      RCD_RUN:
      begin
        if (!run_ok)
        begin
          // Stopping may shorten a high phase; base clock may be gone
          next_out = 1'b0;
          next_state = RCD_IDLE;
        end
        else if (act_div == 4'h0)
          next_out = base_lvl;
        else if (base_rise)
        begin
          if (cnt == half - 15'h0001)
          begin
            next_cnt = 15'h0000;
            next_out = ~out;
          end
          else
            next_cnt = cnt + 15'h0001;
        end
        // swap settings at a low boundary
        if (run_ok && !next_out && next_cnt == 15'h0000 &&
            (act_div != 4'h0 || !base_lvl))
        begin
          next_act_src = ctrl.source_select;
          next_act_div = ctrl.divisor_select;
        end
      end
      default:
        next_state = RCD_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      posc_sync <= 3'b000;
      sys_sync <= 3'b000;
      posc_flt <= 1'b0;
      sys_flt <= 1'b0;
      state <= RCD_IDLE;
      act_src <= 1'b0;
      act_div <= 4'h0;
      cnt <= 15'h0000;
      out <= 1'b0;
    end
    else
    begin
      posc_sync <= {posc_sync[1:0], primary_osc_i};
      sys_sync <= {sys_sync[1:0], system_clock_i};
      posc_flt <= next_posc_flt;
      sys_flt <= next_sys_flt;
      state <= next_state;
      act_src <= next_act_src;
      act_div <= next_act_div;
      cnt <= next_cnt;
      out <= next_out;
    end
  end

  assign ref_clock_pin_o = out;
  assign primary_osc_enable_o = osc_on;

endmodule

// [rcd_ref_properties.sv]
`timescale 1ns/100ps
module rcd_ref_props(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic primary_mode_i,
  input wire logic primary_osc_enable_o,
  input wire logic ref_clock_pin_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  chk_ack_due: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not idle");
  chk_unused_zero: assert property (wb_ack_o |->
    wb_dat_o[31:16] == 16'h0 && !wb_dat_o[14] && wb_dat_o[7:3] == 5'h0)
    else $error("unused bits set");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !ref_clock_pin_o)
    else $error("pin high after reset");
  chk_osc_awake: assert property (!sleep_i || primary_mode_i |->
    primary_osc_enable_o) else $error("oscillator off");
  chk_sleep_stop: assert property (
    (sleep_i && !primary_osc_enable_o)[*3] |-> !ref_clock_pin_o)
    else $error("pin runs without oscillator");
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, slp = 1'b0, pm = 1'b0, clr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic ack, posc, sys, osc_on, pin;
  int bad_count = 0, cmp_count = 0, rises;
  always #25 clk_i = ~clk_i;
  rcd_ref_clock dut(.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(4'hf), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .primary_osc_i(posc),
    .system_clock_i(sys), .sleep_i(slp), .primary_mode_i(pm),
    .primary_osc_enable_o(osc_on), .ref_clock_pin_o(pin));
  rcd_clock_partner far(.osc_on_i(osc_on), .sleep_i(slp), .pin_i(pin),
    .clr_i(clr), .posc_o(posc), .sys_o(sys), .rises_o(rises));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Ack and data taken at the rising edge, released right there
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      bad_count++;
      complete_run();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Settle past a slow boundary, then count pin edges
  task automatic count(input int e);
    repeat (128) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (512) @(posedge clk_i);
    `CHK(rises >= e - (e != 0) && rises <= e + (e != 0), 1'b1)
  endtask
  task automatic t_regs();
    wb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, 8'h00, 32'hffff_ffff);
    wb(1'b0, 8'h00, 32'h0);
    `CHK(rd, 32'h0000_bf00)
    wb(1'b0, 8'h0c, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b1, 8'h00, 32'h0);
    count(0);
    $display("register test done");
  endtask
  task automatic t_div();
    for (int s = 0; s < 2; s++)
      for (int d = 0; d < 4; d++)
      begin
        wb(1'b1, 8'h00, 32'h8000 | (s << 12) | (d << 8));
        count((s ? 64 : 32) >> d);
      end
    // Largest divisor: first rise lies far beyond the window
    wb(1'b1, 8'h00, 32'h9f00);
    count(0);
    $display("divider test done");
  endtask
  task automatic t_sleep();
    wb(1'b1, 8'h00, 32'hb100);
    slp <= 1'b1;
    count(0);
    `CHK(osc_on, 1'b0)
    wb(1'b0, 8'h08, 32'h0);
    `CHK(rd, 32'h0)
    pm <= 1'b1;
    count(32);
    wb(1'b1, 8'h00, 32'h9000);
    count(0);
    wb(1'b1, 8'h00, 32'ha000);
    count(0);
    pm <= 1'b0;
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h1)
    wb(1'b1, 8'h00, 32'hb000);
    count(64);
    wb(1'b0, 8'h08, 32'h0);
    `CHK(rd[2:1], 2'b11)
    slp <= 1'b0;
    $display("sleep test done");
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_div();
    t_sleep();
    complete_run();
  end
endmodule
bind rcd_ref_clock rcd_ref_props chk(.*);
